// ===== hw/pmon_regs_pkg.sv
// Package for the power monitor register side: offsets, status bit
// positions, reset values and widths.
// Assumes a single 40 MHz system clock and a 16-bit register data path.
package pmon_regs_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int NUM_CH = 2;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, word registers on even offsets)
  // ---------------------------------------------------------------
  localparam logic [15:0] POINTER_READ_OFF = 16'h0000;
  localparam logic [15:0] STATUS_OFF = 16'h0002;
  localparam logic [15:0] COEF_OFF = 16'h00FA;
  localparam logic [15:0] RANGE_OFF = 16'h00FC;
  localparam logic [15:0] NO_LOAD_OFF = 16'h00FE;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] POINTER_RST = 16'h0000;
  localparam logic [15:0] COEF_RST = 16'h0000;
  localparam logic [15:0] RANGE_RST = 16'h0000;
  localparam logic [15:0] NO_LOAD_RST = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int MAINS_FAIL_BIT = 12;
  localparam int SECOND_TRIG_BIT = 11;
  localparam int FIRST_TRIG_BIT = 10;
  localparam int SWELL_BIT = 1;
  localparam int DIP_BIT = 0;
  // Per channel positions, index 0 is channel 1, index 1 is channel 2
  localparam int POW_LIMIT_BIT [NUM_CH] = '{3, 9};
  localparam int CUR_LIMIT_BIT [NUM_CH] = '{2, 8};
  localparam int REACT_SIGN_BIT [NUM_CH] = '{5, 7};
  localparam int ACT_SIGN_BIT [NUM_CH] = '{4, 6};
  // Latched flags, cleared only by an explicit clear
  localparam logic [15:0] LATCHED_MASK = 16'h0C03;
  localparam logic [15:0] STATUS_RST = 16'h0000;

endpackage

// ===== hw/system_state_word.sv
// System status word builder with live and latched flag bits.
// Assumes engine inputs are synchronous to clock_i; clear comes from
// the host path as a per-bit mask strobe.
`timescale 1ns/10ps
`default_nettype none

module system_state_word
  import pmon_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Engine status inputs
  input wire logic mains_detect_fail_i,
  input wire logic second_trigger_i,
  input wire logic first_trigger_i,
  input wire logic line_swell_i,
  input wire logic line_dip_i,
  input wire logic [NUM_CH-1:0] power_limit_i,
  input wire logic [NUM_CH-1:0] current_limit_i,
  input wire logic [NUM_CH-1:0] reactive_sign_i,
  input wire logic [NUM_CH-1:0] active_sign_i,
  // Host clear request
  input wire logic flag_clear_i,
  input wire logic [DATA_W-1:0] flag_clear_mask_i,
  // Status word
  output logic [DATA_W-1:0] status_o
);

  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] live_next;
  logic [DATA_W-1:0] latch_reg;
  logic [DATA_W-1:0] latch_next;
  logic [DATA_W-1:0] live_reg;

  // ---------------------------------------------------------------
  // Per channel live bits
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ch_bits [NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // Channel bit placement
      always_comb begin
        ch_bits[ch] = '0;
        ch_bits[ch][POW_LIMIT_BIT[ch]] = power_limit_i[ch];
        ch_bits[ch][CUR_LIMIT_BIT[ch]] = current_limit_i[ch];
        ch_bits[ch][REACT_SIGN_BIT[ch]] = reactive_sign_i[ch];
        ch_bits[ch][ACT_SIGN_BIT[ch]] = active_sign_i[ch];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------
  always_comb begin
    live_next = ch_bits[0] | ch_bits[1];
    live_next[MAINS_FAIL_BIT] = mains_detect_fail_i;
    set_vec = '0;
    set_vec[SECOND_TRIG_BIT] = second_trigger_i;
    set_vec[FIRST_TRIG_BIT] = first_trigger_i;
    set_vec[SWELL_BIT] = line_swell_i;
    set_vec[DIP_BIT] = line_dip_i;
    clr_vec = flag_clear_i ? (flag_clear_mask_i & LATCHED_MASK) : '0;
    latch_next = ((latch_reg & ~clr_vec) | set_vec) & LATCHED_MASK;
  end

  // Register stage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      live_reg <= STATUS_RST;
      latch_reg <= STATUS_RST;
    end else begin
      live_reg <= live_next;
      latch_reg <= latch_next;
    end
  end

  assign status_o = (live_reg & ~LATCHED_MASK) | latch_reg;

endmodule

`default_nettype wire

// ===== hw/power_monitor_status_regs.sv
// Register side of a dual channel power monitor: address pointer,
// frequency compensation and no-load registers, and the status word.
// Assumes an upstream command decoder that turns serial frames into
// single-cycle set-pointer, read, write and clear strobes.
// Answers come one cycle after a strobe; a read or write in the cycle
// of a set-pointer still uses the old pointer.
//
// Behaviour
// - 16-bit pointer addresses every read and write
// - Pointer changes only by set-pointer command
// - Status word ignores host writes
// - Status bits 15 to 13 read zero
// - Bit 12 shows mains detection failure
// - Bit 11 latches second trigger event
// - Bit 10 latches first trigger event
// - Bit 9 shows channel 2 power limit
// - Bit 8 shows channel 2 current limit
// - Bit 7 shows channel 2 reactive sign
// - Bit 6 shows channel 2 active sign
// - No-load threshold register at 0x00FE
// - Compensation coefficient and range registers
// - Bit 1 latches line swell
// - Bit 0 latches line dip
// - Bits 3 and 2 channel 1 limits
// - Bits 5 and 4 channel 1 signs
`timescale 1ns/10ps
`default_nettype none

module power_monitor_status_regs
  import pmon_regs_pkg::*;
#(
  parameter logic [DATA_W-1:0] NO_LOAD_RESET = NO_LOAD_RST
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Set-pointer command
  input wire logic set_ptr_i,
  input wire logic [ADDR_W-1:0] ptr_data_i,
  // Register read command
  input wire logic rd_req_i,
  // Register write command
  input wire logic wr_req_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  // Latched flag clear command
  input wire logic flag_clear_i,
  input wire logic [DATA_W-1:0] flag_clear_mask_i,
  // Engine status inputs
  input wire logic mains_detect_fail_i,
  input wire logic second_trigger_flag_i,
  input wire logic first_trigger_flag_i,
  input wire logic line_swell_flag_i,
  input wire logic line_dip_flag_i,
  input wire logic ch1_power_limit_flag_i,
  input wire logic ch2_power_limit_flag_i,
  input wire logic ch1_current_limit_flag_i,
  input wire logic ch2_current_limit_flag_i,
  input wire logic ch1_reactive_sign_i,
  input wire logic ch2_reactive_sign_i,
  input wire logic ch1_active_sign_i,
  input wire logic ch2_active_sign_i,
  // Read answer
  output logic rd_valid_o,
  output logic rd_err_o,
  output logic [DATA_W-1:0] rd_data_o,
  // Write answer
  output logic wr_done_o,
  output logic wr_err_o,
  // Register contents to the engine
  output logic [ADDR_W-1:0] register_target_pointer_o,
  output logic [DATA_W-1:0] current_rms_gain_freq_comp_coef_o,
  output logic [DATA_W-1:0] current_rms_gain_freq_comp_range_o,
  output logic [DATA_W-1:0] no_load_threshold_o,
  output logic [DATA_W-1:0] system_state_word_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Pointer and register file state
  logic [ADDR_W-1:0] pointer_reg;
  logic [ADDR_W-1:0] pointer_next;
  logic [DATA_W-1:0] coef_reg;
  logic [DATA_W-1:0] coef_next;
  logic [DATA_W-1:0] range_reg;
  logic [DATA_W-1:0] range_next;
  logic [DATA_W-1:0] no_load_reg;
  logic [DATA_W-1:0] no_load_next;

  // Status word from the flag builder
  logic [DATA_W-1:0] status_word;

  // Read and write answer state
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic rd_err_reg;
  logic rd_err_next;
  logic wr_done_reg;
  logic wr_done_next;
  logic wr_err_reg;
  logic wr_err_next;

  // Address decode results
  logic hit_coef;
  logic hit_range;
  logic hit_no_load;
  logic hit_status;
  logic hit_ptr_read;
  logic wr_ok;
  logic [DATA_W-1:0] read_mux;
  logic read_mapped;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  system_state_word u_status (
    // Clock and reset
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    // Engine status inputs
    .mains_detect_fail_i(mains_detect_fail_i),
    .second_trigger_i(second_trigger_flag_i),
    .first_trigger_i(first_trigger_flag_i),
    .line_swell_i(line_swell_flag_i),
    .line_dip_i(line_dip_flag_i),
    .power_limit_i({ch2_power_limit_flag_i, ch1_power_limit_flag_i}),
    .current_limit_i({ch2_current_limit_flag_i, ch1_current_limit_flag_i}),
    .reactive_sign_i({ch2_reactive_sign_i, ch1_reactive_sign_i}),
    .active_sign_i({ch2_active_sign_i, ch1_active_sign_i}),
    // Host clear and status word
    .flag_clear_i(flag_clear_i),
    .flag_clear_mask_i(flag_clear_mask_i),
    .status_o(status_word)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  always_comb begin
    // Writable registers
    hit_coef = (pointer_reg == COEF_OFF);
    hit_range = (pointer_reg == RANGE_OFF);
    hit_no_load = (pointer_reg == NO_LOAD_OFF);
    // Read-only places
    hit_status = (pointer_reg == STATUS_OFF);
    hit_ptr_read = (pointer_reg == POINTER_READ_OFF);
  end

  // Writable targets only
  // read-only places excluded
  assign wr_ok = hit_coef | hit_range | hit_no_load;

  // ---------------------------------------------------------------
  // Address pointer
  // ---------------------------------------------------------------

  // Next pointer value
  always_comb begin
    pointer_next = pointer_reg;
    if (set_ptr_i) begin
      pointer_next = ptr_data_i;
    end
  end

  // Pointer register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pointer_reg <= POINTER_RST;
    end else begin
      pointer_reg <= pointer_next;
    end
  end

  // ---------------------------------------------------------------
  // Compensation and no-load registers
  // ---------------------------------------------------------------

  // Next register values from the write path
  // Refused writes leave registers unchanged
  always_comb begin
    coef_next = coef_reg;
    range_next = range_reg;
    no_load_next = no_load_reg;
    if (wr_req_i) begin
      if (hit_coef) begin
        coef_next = wr_data_i;
      end
      if (hit_range) begin
        range_next = wr_data_i;
      end
      if (hit_no_load) begin
        no_load_next = wr_data_i;
      end
    end
  end

  // Register stage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      coef_reg <= COEF_RST;
      range_reg <= RANGE_RST;
      no_load_reg <= NO_LOAD_RESET;
    end else begin
      coef_reg <= coef_next;
      range_reg <= range_next;
      no_load_reg <= no_load_next;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Read data select
  always_comb begin
    read_mux = READ_ZERO;
    read_mapped = 1'b1;
    if (hit_coef) begin
      read_mux = coef_reg;
    end else if (hit_range) begin
      read_mux = range_reg;
    end else if (hit_no_load) begin
      read_mux = no_load_reg;
    end else if (hit_status) begin
      read_mux = status_word;
    end else if (hit_ptr_read) begin
      read_mux = pointer_reg;
    end else begin
      read_mapped = 1'b0; // Unmapped reads as zero
    end
  end

  // Read answer next values
  always_comb begin
    // One answer pulse per request
    rd_valid_next = rd_req_i;
    rd_err_next = rd_req_i & ~read_mapped;
    // Read data holds until the next read
    rd_data_next = rd_data_reg;
    if (rd_req_i) begin
      rd_data_next = read_mux;
    end
  end

  // ---------------------------------------------------------------
  // Write answer
  // ---------------------------------------------------------------

  // Write answer next values
  always_comb begin
    wr_done_next = wr_req_i;
    wr_err_next = wr_req_i & ~wr_ok;
  end

  // Answer registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd_valid_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      rd_data_reg <= READ_ZERO;
      wr_done_reg <= 1'b0;
      wr_err_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_err_reg <= rd_err_next;
      rd_data_reg <= rd_data_next;
      wr_done_reg <= wr_done_next;
      wr_err_reg <= wr_err_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Answer pulses and read data
  assign rd_valid_o = rd_valid_reg;
  assign rd_err_o = rd_err_reg;
  assign rd_data_o = rd_data_reg;
  assign wr_done_o = wr_done_reg;
  assign wr_err_o = wr_err_reg;

  // Register contents to the engine
  assign register_target_pointer_o = pointer_reg;
  assign current_rms_gain_freq_comp_coef_o = coef_reg;
  assign current_rms_gain_freq_comp_range_o = range_reg;
  assign no_load_threshold_o = no_load_reg;
  assign system_state_word_o = status_word;

endmodule

`default_nettype wire

// ===== verif/pmon_regs_chk_sva.sv
// Checker for the power monitor register side.
// Assumes one clock domain and a bind onto the register block.
`timescale 1ns/10ps
`default_nettype none

module pmon_regs_chk
  import pmon_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Commands
  input wire logic set_ptr_i,
  input wire logic [ADDR_W-1:0] ptr_data_i,
  input wire logic rd_req_i,
  input wire logic wr_req_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic flag_clear_i,
  input wire logic [DATA_W-1:0] flag_clear_mask_i,
  // Engine inputs
  input wire logic mains_detect_fail_i,
  input wire logic first_trigger_flag_i,
  input wire logic second_trigger_flag_i,
  input wire logic line_swell_flag_i,
  input wire logic line_dip_flag_i,
  input wire logic ch2_power_limit_flag_i,
  input wire logic ch2_current_limit_flag_i,
  input wire logic ch2_reactive_sign_i,
  input wire logic ch2_active_sign_i,
  // Answers and contents
  input wire logic rd_valid_o,
  input wire logic rd_err_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic wr_done_o,
  input wire logic wr_err_o,
  input wire logic [ADDR_W-1:0] register_target_pointer_o,
  input wire logic [DATA_W-1:0] no_load_threshold_o,
  input wire logic [DATA_W-1:0] system_state_word_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Latched bits that must survive this cycle
  logic [DATA_W-1:0] keep;
  assign keep = system_state_word_o & LATCHED_MASK &
    ~(flag_clear_i ? flag_clear_mask_i : 16'h0000);
  sequence s_rd_status;
    !sys_rst_i && rd_req_i && register_target_pointer_o == STATUS_OFF;
  endsequence
  sequence s_wr_noload;
    !sys_rst_i && wr_req_i && register_target_pointer_o == NO_LOAD_OFF;
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_top_zero: assert property (
    system_state_word_o[15:13] == 3'h0) else $error("top bits set");
  chk_mains_live: assert property (
    !$past(sys_rst_i) |-> system_state_word_o[12] ==
    $past(mains_detect_fail_i)) else $error("mains bit wrong");
  chk_ch2_power: assert property (
    !$past(sys_rst_i) |-> system_state_word_o[9] ==
    $past(ch2_power_limit_flag_i)) else $error("ch2 power bit wrong");
  chk_ch2_current: assert property (
    !$past(sys_rst_i) |-> system_state_word_o[8] ==
    $past(ch2_current_limit_flag_i)) else $error("ch2 current bit wrong");
  chk_ch2_signs: assert property (
    !$past(sys_rst_i) |-> system_state_word_o[7:6] ==
    $past({ch2_reactive_sign_i, ch2_active_sign_i}))
    else $error("ch2 sign bits wrong");
  chk_first_set: assert property (
    !sys_rst_i && first_trigger_flag_i |=> system_state_word_o[10])
    else $error("first flag not set");
  chk_second_set: assert property (
    !sys_rst_i && second_trigger_flag_i |=> system_state_word_o[11])
    else $error("second flag not set");
  chk_swell_dip: assert property (
    !sys_rst_i |=> (system_state_word_o[1:0] &
    $past({line_swell_flag_i, line_dip_flag_i})) ==
    $past({line_swell_flag_i, line_dip_flag_i}))
    else $error("swell or dip flag not set");
  chk_latch_hold: assert property (
    !sys_rst_i |=> (system_state_word_o & $past(keep)) == $past(keep))
    else $error("latched flag lost");
  chk_clear_works: assert property (
    !sys_rst_i && flag_clear_i && flag_clear_mask_i[10] &&
    !first_trigger_flag_i |=> !system_state_word_o[10])
    else $error("clear ignored");
  chk_ptr_set: assert property (
    !sys_rst_i && set_ptr_i |=> register_target_pointer_o ==
    $past(ptr_data_i)) else $error("pointer not loaded");
  chk_ptr_hold: assert property (
    !sys_rst_i && !set_ptr_i |=> $stable(register_target_pointer_o))
    else $error("pointer moved");
  chk_rd_status: assert property (
    s_rd_status |=> rd_valid_o && !rd_err_o &&
    rd_data_o == $past(system_state_word_o)) else $error("status read");
  chk_wr_noload: assert property (
    s_wr_noload |=> wr_done_o && !wr_err_o &&
    no_load_threshold_o == $past(wr_data_i)) else $error("no-load write");
  chk_wr_status: assert property (
    !sys_rst_i && wr_req_i && register_target_pointer_o == STATUS_OFF
    |=> wr_done_o && wr_err_o) else $error("status write taken");
endmodule

bind power_monitor_status_regs pmon_regs_chk chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .set_ptr_i(set_ptr_i),
  .ptr_data_i(ptr_data_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
  .wr_data_i(wr_data_i), .flag_clear_i(flag_clear_i),
  .flag_clear_mask_i(flag_clear_mask_i),
  .mains_detect_fail_i(mains_detect_fail_i),
  .first_trigger_flag_i(first_trigger_flag_i),
  .second_trigger_flag_i(second_trigger_flag_i),
  .line_swell_flag_i(line_swell_flag_i),
  .line_dip_flag_i(line_dip_flag_i),
  .ch2_power_limit_flag_i(ch2_power_limit_flag_i),
  .ch2_current_limit_flag_i(ch2_current_limit_flag_i),
  .ch2_reactive_sign_i(ch2_reactive_sign_i),
  .ch2_active_sign_i(ch2_active_sign_i), .rd_valid_o(rd_valid_o),
  .rd_err_o(rd_err_o), .rd_data_o(rd_data_o), .wr_done_o(wr_done_o),
  .wr_err_o(wr_err_o),
  .register_target_pointer_o(register_target_pointer_o),
  .no_load_threshold_o(no_load_threshold_o),
  .system_state_word_o(system_state_word_o)
);
`default_nettype wire

// ===== verif/pmon_host_model.sv
// Host controller model issuing decoded register commands.
// Assumes commands start at a rising edge of clock_i.
`timescale 1ns/10ps
`default_nettype none

module pmon_host_model
  import pmon_regs_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Commands
  output logic set_ptr_o,
  output logic [ADDR_W-1:0] ptr_data_o,
  output logic rd_req_o,
  output logic wr_req_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic flag_clear_o,
  output logic [DATA_W-1:0] flag_clear_mask_o,
  // Answers
  input wire logic rd_valid_i,
  input wire logic rd_err_i,
  input wire logic [DATA_W-1:0] rd_data_i
);
  // Idle command lines
  initial begin
    {set_ptr_o, rd_req_o, wr_req_o, flag_clear_o} = 4'h0;
    {ptr_data_o, wr_data_o, flag_clear_mask_o} = 48'h0;
  end

  task automatic do_set(input logic [ADDR_W-1:0] p);
    set_ptr_o <= 1'b1;
    ptr_data_o <= p;
    @(posedge clock_i);
    set_ptr_o <= 1'b0;
    ptr_data_o <= ~p;
  endtask

  // Read at pointer, answer sampled just after the taking edge
  task automatic do_rd(output logic [DATA_W-1:0] d, output logic e,
                       output logic ok);
    rd_req_o <= 1'b1;
    @(posedge clock_i);
    rd_req_o <= 1'b0;
    #1;
    ok = (rd_valid_i === 1'b1);
    e = rd_err_i;
    d = rd_data_i;
    @(posedge clock_i);
  endtask

  // Write at pointer, data stale-inverted after the strobe
  task automatic do_wr(input logic [DATA_W-1:0] v);
    wr_req_o <= 1'b1;
    wr_data_o <= v;
    @(posedge clock_i);
    wr_req_o <= 1'b0;
    wr_data_o <= ~v;
    @(posedge clock_i);
  endtask

  // Clear latched flags by mask
  task automatic do_clr(input logic [DATA_W-1:0] m);
    flag_clear_o <= 1'b1;
    flag_clear_mask_o <= m;
    @(posedge clock_i);
    flag_clear_o <= 1'b0;
    flag_clear_mask_o <= ~m;
  endtask
endmodule
`default_nettype wire

// ===== verif/power_monitor_status_regs_tb.sv
// Testbench for the register side: registers, pointer, status word.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module power_monitor_status_regs_tb;
  import pmon_regs_pkg::*;
  logic clock_i, sys_rst_i, sp, rq, wq, fc, rv, re, wd, we, e, ok;
  logic [15:0] pd, wdat, fm, rdat, ptr, cf, rg, nl, st, d;
  logic [12:0] eng;
  int err_total, total_checks;
  logic [15:0] offs [3] = '{COEF_OFF, RANGE_OFF, NO_LOAD_OFF};
  logic [15:0] vals [3] = '{16'h1234, 16'hFFFF, 16'h8001};
  int lv [9] = '{12, 9, 8, 7, 6, 5, 4, 3, 2};
  int lat [4] = '{11, 10, 1, 0};

  // Clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  pmon_host_model host (.clock_i(clock_i), .set_ptr_o(sp),
    .ptr_data_o(pd), .rd_req_o(rq), .wr_req_o(wq), .wr_data_o(wdat),
    .flag_clear_o(fc), .flag_clear_mask_o(fm), .rd_valid_i(rv),
    .rd_err_i(re), .rd_data_i(rdat));

  power_monitor_status_regs dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .set_ptr_i(sp), .ptr_data_i(pd),
    .rd_req_i(rq), .wr_req_i(wq), .wr_data_i(wdat), .flag_clear_i(fc),
    .flag_clear_mask_i(fm), .mains_detect_fail_i(eng[12]),
    .second_trigger_flag_i(eng[11]), .first_trigger_flag_i(eng[10]),
    .line_swell_flag_i(eng[1]), .line_dip_flag_i(eng[0]),
    .ch1_power_limit_flag_i(eng[3]), .ch2_power_limit_flag_i(eng[9]),
    .ch1_current_limit_flag_i(eng[2]),
    .ch2_current_limit_flag_i(eng[8]), .ch1_reactive_sign_i(eng[5]),
    .ch2_reactive_sign_i(eng[7]), .ch1_active_sign_i(eng[4]),
    .ch2_active_sign_i(eng[6]), .rd_valid_o(rv), .rd_err_o(re),
    .rd_data_o(rdat), .wr_done_o(wd), .wr_err_o(we),
    .register_target_pointer_o(ptr),
    .current_rms_gain_freq_comp_coef_o(cf),
    .current_rms_gain_freq_comp_range_o(rg),
    .no_load_threshold_o(nl), .system_state_word_o(st));

  // ---------------------------------------------------------------
  // Checking tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read and compare data and error flag; a missing answer ends the run
  task automatic rd_cmp(input logic [15:0] exp, input logic eexp);
    host.do_rd(d, e, ok);
    cmp({15'h0000, ok}, 16'h0001);
    if (!ok) report_and_stop();
    cmp({15'h0000, e}, {15'h0000, eexp});
    cmp(d, exp);
  endtask

  // Write, then check answer pulses seen one cycle after the strobe
  task automatic wr_cmp(input logic [15:0] v, input logic eexp);
    fork
      host.do_wr(v);
      begin
        @(posedge clock_i);
        #1;
        cmp({14'h0000, wd, we}, {14'h0000, 1'b1, eexp});
      end
    join
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    eng = 13'h0000;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    cmp(ptr, POINTER_RST);
    cmp(cf, COEF_RST);
    cmp(rg, RANGE_RST);
    cmp(nl, NO_LOAD_RST);
    cmp(st, STATUS_RST);
    $display("test reset done");
    @(posedge clock_i);
    // Compensation and no-load registers, write then read back
    for (int i = 0; i < 3; i++) begin
      host.do_set(offs[i]);
      wr_cmp(vals[i], 1'b0);
      rd_cmp(vals[i], 1'b0);
      cmp(ptr, offs[i]);
    end
    cmp(cf, vals[0]);
    cmp(rg, vals[1]);
    cmp(nl, vals[2]);
    $display("test registers done");
    // Pointer readback is not writable, unmapped place errors
    host.do_set(POINTER_READ_OFF);
    wr_cmp(16'hBEEF, 1'b1);
    cmp(ptr, POINTER_READ_OFF);
    rd_cmp(POINTER_READ_OFF, 1'b0);
    host.do_set(16'h0010);
    rd_cmp(READ_ZERO, 1'b1);
    host.do_set(STATUS_OFF);
    wr_cmp(16'hFFFF, 1'b1);
    rd_cmp(STATUS_RST, 1'b0);
    $display("test pointer done");
    // Live bits follow the engine one at a time
    foreach (lv[k]) begin
      eng <= 13'h0001 << lv[k];
      @(posedge clock_i);
      rd_cmp(16'h0001 << lv[k], 1'b0);
    end
    eng <= 13'h0000;
    @(posedge clock_i);
    $display("test live done");
    // Latched bits stay set across reads until cleared
    foreach (lat[k]) begin
      eng <= 13'h0001 << lat[k];
      @(posedge clock_i);
      eng <= 13'h0000;
      @(posedge clock_i);
      rd_cmp(16'h0001 << lat[k], 1'b0);
      rd_cmp(16'h0001 << lat[k], 1'b0);
      host.do_clr(16'h0001 << lat[k]);
      rd_cmp(STATUS_RST, 1'b0);
    end
    // All inputs high: set beats clear, top bits stay zero
    eng <= 13'h1FFF;
    @(posedge clock_i);
    host.do_clr(16'hFFFF);
    rd_cmp(16'h1FFF, 1'b0);
    eng <= 13'h0000;
    host.do_clr(16'hFFFF);
    rd_cmp(STATUS_RST, 1'b0);
    $display("test latched done");
    report_and_stop();
  end
endmodule
`default_nettype wire
